// ### design/csdec_pkg.sv
// constants shared by the chip-select decode unit
package csdec_pkg;
	localparam int          NUM_BANKS       = 8;            // select outputs
	localparam int          NUM_LANES       = 4;            // data byte lanes
	// register map (byte offsets, one word per register)
	localparam logic [11:0] BANK_REG_BASE   = 12'h080;      // bank 0 base register
	localparam int          BANK_STRIDE     = 12;           // bytes per bank triple
	localparam logic [1:0]  KIND_BASE       = 2'h0;         // bank_base_reg
	localparam logic [1:0]  KIND_MASK       = 2'h1;         // bank_mask_reg
	localparam logic [1:0]  KIND_CTRL       = 2'h2;         // bank_control_reg
	// bank_base_reg / bank_mask_reg fields
	localparam int          ADDR_FIELD_LSB  = 16;           // base and mask in [31:16]
	localparam int          MASK_WP_BIT     = 8;            // write protect
	localparam int          MASK_VALID_BIT  = 0;            // bank valid
	// bank_control_reg fields
	localparam int          CTRL_WS_LSB     = 10;           // wait states [13:10]
	localparam int          CTRL_AA_BIT     = 8;            // auto_ack
	localparam int          CTRL_PW_LSB     = 6;            // port_width [7:6]
	localparam int          CTRL_BEM_BIT    = 5;            // lane_strobe_mode
	localparam int          CTRL_BSTR_BIT   = 4;            // read burst capable
	localparam int          CTRL_BSTW_BIT   = 3;            // write burst capable
	// writable bits of each register, all else reads zero
	localparam logic [31:0] BASE_WR_MASK    = 32'hFFFF0000;
	localparam logic [31:0] MASK_WR_MASK    = 32'hFFFF0101;
	localparam logic [31:0] CTRL_WR_MASK    = 32'h00003DF8;
	// reset values
	localparam logic [31:0] BASE_RST        = 32'h00000000;
	localparam logic [31:0] MASK_RST        = 32'h00000000;
	localparam logic [31:0] CTRL_RST        = 32'h00000000;
	localparam logic [3:0]  BOOT_AA_WAITS   = 4'hF;         // strapped auto_ack wait count
	// port_width encoding, same as the strap on data pins 6:5
	localparam logic [1:0]  PW_32           = 2'h0;
	localparam logic [1:0]  PW_8            = 2'h1;
	// transfer size encoding
	localparam logic [1:0]  SZ_LONG         = 2'h0;
	localparam logic [1:0]  SZ_BYTE         = 2'h1;
	localparam logic [1:0]  SZ_WORD         = 2'h2;
	localparam logic [1:0]  SZ_LINE         = 2'h3;
	// active-high lane sets, bit 3 is D[31:24]
	localparam logic [3:0]  LANES_TOP       = 4'h8;
	localparam logic [3:0]  LANES_SECOND    = 4'h4;
	localparam logic [3:0]  LANES_UPPER     = 4'hC;
	localparam logic [3:0]  LANES_LOWER     = 4'h3;
	localparam logic [3:0]  LANES_ALL       = 4'hF;
	// axi responses
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage

// ### design/bank_match_if.sv
// per-bank compare signals between the top and one bank comparator
`timescale 1ns/1ps
`default_nettype none
interface bank_match_if;
	logic [15:0] addr_hi;      // address bits 31:16 of the cycle
	logic        is_write;     // cycle is a write
	logic        usable;       // bank may decode at all
	logic [15:0] base;         // programmed base
	logic [15:0] mask;         // programmed mask, 1 = ignore bit
	logic        valid;        // bank valid bit
	logic        wr_protect;   // writes do not match
	logic        hit;          // bank matches this cycle
	modport top (output addr_hi, is_write, usable, base, mask, valid, wr_protect, input hit);
	modport bank (input addr_hi, is_write, usable, base, mask, valid, wr_protect, output hit);
endinterface
`default_nettype wire

// ### design/bank_match.sv
// address compare for one select bank
`timescale 1ns/1ps
`default_nettype none
module bank_match (
	// compare signals
	bank_match_if.bank m
);
	// masked compare of the upper address half plus access qualification
	always_comb
	begin
		m.hit = m.usable && m.valid && !(m.wr_protect && m.is_write) &&
			(((m.addr_hi ^ m.base) & ~m.mask) == 16'h0000);
	end
endmodule
`default_nettype wire

// ### design/chip_select_decode_unit.sv
// chip-select decode unit: register slave, bank decode, select and strobe timing
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - each select has its own settings
// - only bank 0 usable out of reset
// - boot bank configured from D[7:5] at reset
// - read strobe changes on falling edges only
// - read strobe only when a bank matches
// - mode bit picks byte or write enables
// - lane strobes from size, A1:A0, width
// - 8/16-bit ports use upper lanes
// - 32-bit byte/word lanes from A1:A0
// - 32-bit longword and line use all lanes
// - compare all banks and DRAM at start
// - single match uses that bank's settings
// - no match: external, non-burst, 32-bit
// - multi match: matching selects, external, 32-bit
// - selects work for CPU-space, external masters
// - writes drive all four data lanes
// - boot select catches all until valid
// - D7 strap sets boot auto_ack
// - D6:5 strap sets boot port_width
// - valid set ends catch-all until reset
// - per-bank masking, qualification, waits, auto_ack
// - base compared with address bits 31:16
module chip_select_decode_unit #(
	parameter int AXI_AW = 12                        // register bus address width
) (
	// clock and reset
	input  wire logic              CLK_I,
	input  wire logic              RSTN_I,
	// axi4-lite write address and data
	input  wire logic [AXI_AW-1:0] S_AXI_AWADDR_I,
	input  wire logic              S_AXI_AWVALID_I,
	output logic                   S_AXI_AWREADY_O,
	input  wire logic [31:0]       S_AXI_WDATA_I,
	input  wire logic [3:0]        S_AXI_WSTRB_I,
	input  wire logic              S_AXI_WVALID_I,
	output logic                   S_AXI_WREADY_O,
	// axi4-lite write response
	output logic [1:0]             S_AXI_BRESP_O,
	output logic                   S_AXI_BVALID_O,
	input  wire logic              S_AXI_BREADY_I,
	// axi4-lite read
	input  wire logic [AXI_AW-1:0] S_AXI_ARADDR_I,
	input  wire logic              S_AXI_ARVALID_I,
	output logic                   S_AXI_ARREADY_O,
	output logic [31:0]            S_AXI_RDATA_O,
	output logic [1:0]             S_AXI_RRESP_O,
	output logic                   S_AXI_RVALID_O,
	input  wire logic              S_AXI_RREADY_I,
	// bus cycle from the internal bus or an external master
	input  wire logic              CYC_START_I,
	input  wire logic [31:0]       CYC_ADDR_I,
	input  wire logic [1:0]        CYC_SIZE_I,
	input  wire logic              CYC_READ_I,
	input  wire logic [1:0]        DRAM_HIT_I,
	// pins sampled from outside
	input  wire logic [2:0]        DATA_STRAP_I,
	input  wire logic              EXT_TA_N_I,
	// memory-side outputs
	output logic [7:0]             CS_N_O,
	output logic                   OE_N_O,
	output logic [3:0]             LANE_STROBE_N_O,
	output logic [3:0]             DATA_LANE_OE_O,
	// cycle attributes and termination
	output logic                   CYC_ACTIVE_O,
	output logic                   CYC_BURST_OK_O,
	output logic                   CYC_EXT_TERM_O,
	output logic [1:0]             CYC_PORT_WIDTH_O,
	output logic                   CYC_DONE_O,
	output logic                   AUTO_ACK_O
);
	localparam int NB = csdec_pkg::NUM_BANKS;

	// reset release through two flip-flops
	logic rst_meta_ff;
	logic rst_n;
	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
		begin
			rst_meta_ff <= 1'b0;
			rst_n       <= 1'b0;
		end
		else
		begin
			rst_meta_ff <= 1'b1;
			rst_n       <= rst_meta_ff;
		end
	end

	// pin synchronisers, three stages each
	logic [2:0] strap_s1_ff, strap_s2_ff, strap_s3_ff;
	logic       ta_s1_ff, ta_s2_ff, ta_s3_ff;
	// strap stages run through reset, so the level held before release is ready
	always_ff @(posedge CLK_I)
	begin
		strap_s1_ff <= DATA_STRAP_I;
		strap_s2_ff <= strap_s1_ff;
		strap_s3_ff <= strap_s2_ff;
	end
	always_ff @(posedge CLK_I or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ta_s1_ff    <= 1'b1;
			ta_s2_ff    <= 1'b1;
			ta_s3_ff    <= 1'b1;
		end
		else
		begin
			ta_s1_ff    <= EXT_TA_N_I;
			ta_s2_ff    <= ta_s1_ff;
			ta_s3_ff    <= ta_s2_ff;
		end
	end
	logic ext_ta_seen;                              // termination once stages two and three agree
	assign ext_ta_seen = !ta_s2_ff && !ta_s3_ff;

	// register file and bus slave state
	logic [31:0]       base_ff [NB], nxt_base [NB];
	logic [31:0]       mask_ff [NB], nxt_mask [NB];
	logic [31:0]       ctrl_ff [NB], nxt_ctrl [NB];
	logic              boot_ff, nxt_boot;            // catch-all boot decoding
	logic              strap_done_ff, nxt_strap_done;
	logic              aw_held_ff, nxt_aw_held;
	logic [AXI_AW-1:0] awaddr_ff, nxt_awaddr;
	logic              w_held_ff, nxt_w_held;
	logic [31:0]       wdata_ff, nxt_wdata;
	logic [3:0]        wstrb_ff, nxt_wstrb;
	logic              bvalid_ff, nxt_bvalid;
	logic [1:0]        bresp_ff, nxt_bresp;
	logic              rvalid_ff, nxt_rvalid;
	logic [31:0]       rdata_ff, nxt_rdata;
	logic [1:0]        rresp_ff, nxt_rresp;

	// register decode: {hit, bank, kind}
	function automatic logic [5:0] reg_decode(input logic [AXI_AW-1:0] a);
		logic [5:0]  r;
		logic [11:0] off;
		r = 6'h00;
		for (int b = 0; b < NB; b++)
			for (int k = 0; k < 3; k++)
			begin
				off = csdec_pkg::BANK_REG_BASE + 12'(b * csdec_pkg::BANK_STRIDE + k * 4);
				if (12'(a) == off)
					r = {1'b1, 3'(b), 2'(k)};
			end
		return r;
	endfunction

	logic [5:0]  wr_dec, rd_dec;
	logic [31:0] byte_mask;
	assign wr_dec = reg_decode(awaddr_ff);
	assign rd_dec = reg_decode(S_AXI_ARADDR_I);

	// handshakes: no new address or data while a response waits
	assign S_AXI_AWREADY_O = !aw_held_ff && !bvalid_ff;
	assign S_AXI_WREADY_O  = !w_held_ff && !bvalid_ff;
	assign S_AXI_ARREADY_O = !rvalid_ff;
	assign S_AXI_BVALID_O  = bvalid_ff;
	assign S_AXI_BRESP_O   = bresp_ff;
	assign S_AXI_RVALID_O  = rvalid_ff;
	assign S_AXI_RDATA_O   = rdata_ff;
	assign S_AXI_RRESP_O   = rresp_ff;

	// next state of registers, straps and bus slave
	always_comb
	begin
		nxt_base       = base_ff;
		nxt_mask       = mask_ff;
		nxt_ctrl       = ctrl_ff;
		nxt_strap_done = 1'b1;
		nxt_aw_held    = aw_held_ff;
		nxt_awaddr     = awaddr_ff;
		nxt_w_held     = w_held_ff;
		nxt_wdata      = wdata_ff;
		nxt_wstrb      = wstrb_ff;
		nxt_bvalid     = bvalid_ff;
		nxt_bresp      = bresp_ff;
		nxt_rvalid     = rvalid_ff;
		nxt_rdata      = rdata_ff;
		nxt_rresp      = rresp_ff;
		byte_mask      = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
		// boot bank configured from the straps in the first cycle after release
		if (!strap_done_ff)
		begin
			nxt_ctrl[0] = csdec_pkg::CTRL_RST;
			nxt_ctrl[0][csdec_pkg::CTRL_AA_BIT] = strap_s3_ff[2];
			nxt_ctrl[0][csdec_pkg::CTRL_WS_LSB +: 4] = strap_s3_ff[2] ? csdec_pkg::BOOT_AA_WAITS : 4'h0;
			nxt_ctrl[0][csdec_pkg::CTRL_PW_LSB +: 2] = strap_s3_ff[1] ? 2'h2 : strap_s3_ff[1:0];
		end
		// capture address and data in either order
		if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)
		begin
			nxt_aw_held = 1'b1;
			nxt_awaddr  = S_AXI_AWADDR_I;
		end
		if (S_AXI_WVALID_I && S_AXI_WREADY_O)
		begin
			nxt_w_held = 1'b1;
			nxt_wdata  = S_AXI_WDATA_I;
			nxt_wstrb  = S_AXI_WSTRB_I;
		end
		// both held: perform the write and answer
		if (aw_held_ff && w_held_ff)
		begin
			nxt_aw_held = 1'b0;
			nxt_w_held  = 1'b0;
			nxt_bvalid  = 1'b1;
			nxt_bresp   = wr_dec[5] ? csdec_pkg::RESP_OKAY : csdec_pkg::RESP_SLVERR;
			for (int b = 0; b < NB; b++)
			begin
				if (wr_dec[5] && wr_dec[4:2] == 3'(b))
				begin
					// each bank keeps its own settings
					case (wr_dec[1:0])
						csdec_pkg::KIND_BASE:
							nxt_base[b] = (base_ff[b] & ~(byte_mask & csdec_pkg::BASE_WR_MASK)) |
								(wdata_ff & byte_mask & csdec_pkg::BASE_WR_MASK);
						csdec_pkg::KIND_MASK:
							nxt_mask[b] = (mask_ff[b] & ~(byte_mask & csdec_pkg::MASK_WR_MASK)) |
								(wdata_ff & byte_mask & csdec_pkg::MASK_WR_MASK);
						default:
							nxt_ctrl[b] = (ctrl_ff[b] & ~(byte_mask & csdec_pkg::CTRL_WR_MASK)) |
								(wdata_ff & byte_mask & csdec_pkg::CTRL_WR_MASK);
					endcase
				end
			end
		end
		if (bvalid_ff && S_AXI_BREADY_I)
			nxt_bvalid = 1'b0;
		// read: answer one cycle after the address is taken
		if (rvalid_ff && S_AXI_RREADY_I)
			nxt_rvalid = 1'b0;
		if (S_AXI_ARVALID_I && S_AXI_ARREADY_O)
		begin
			nxt_rvalid = 1'b1;
			nxt_rdata  = 32'h00000000;
			nxt_rresp  = rd_dec[5] ? csdec_pkg::RESP_OKAY : csdec_pkg::RESP_SLVERR;
			for (int b = 0; b < NB; b++)
			begin
				if (rd_dec[5] && rd_dec[4:2] == 3'(b))
				begin
					case (rd_dec[1:0])
						csdec_pkg::KIND_BASE: nxt_rdata = base_ff[b];
						csdec_pkg::KIND_MASK: nxt_rdata = mask_ff[b];
						default:              nxt_rdata = ctrl_ff[b];
					endcase
				end
			end
		end
		// catch-all ends for good once bank 0 is made valid
		nxt_boot = boot_ff && !mask_ff[0][csdec_pkg::MASK_VALID_BIT];
	end

	// register the register-file and slave group
	always_ff @(posedge CLK_I or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int b = 0; b < NB; b++)
			begin
				base_ff[b] <= csdec_pkg::BASE_RST;
				mask_ff[b] <= csdec_pkg::MASK_RST;
				ctrl_ff[b] <= csdec_pkg::CTRL_RST;
			end
			boot_ff       <= 1'b1;
			strap_done_ff <= 1'b0;
			aw_held_ff    <= 1'b0;
			awaddr_ff     <= '0;
			w_held_ff     <= 1'b0;
			wdata_ff      <= 32'h00000000;
			wstrb_ff      <= 4'h0;
			bvalid_ff     <= 1'b0;
			bresp_ff      <= csdec_pkg::RESP_OKAY;
			rvalid_ff     <= 1'b0;
			rdata_ff      <= 32'h00000000;
			rresp_ff      <= csdec_pkg::RESP_OKAY;
		end
		else
		begin
			base_ff       <= nxt_base;
			mask_ff       <= nxt_mask;
			ctrl_ff       <= nxt_ctrl;
			boot_ff       <= nxt_boot;
			strap_done_ff <= nxt_strap_done;
			aw_held_ff    <= nxt_aw_held;
			awaddr_ff     <= nxt_awaddr;
			w_held_ff     <= nxt_w_held;
			wdata_ff      <= nxt_wdata;
			wstrb_ff      <= nxt_wstrb;
			bvalid_ff     <= nxt_bvalid;
			bresp_ff      <= nxt_bresp;
			rvalid_ff     <= nxt_rvalid;
			rdata_ff      <= nxt_rdata;
			rresp_ff      <= nxt_rresp;
		end
	end

	// one comparator per bank
	logic [NB-1:0] bank_hit;
	bank_match_if bif [NB] ();
	genvar g;
	generate
		for (g = 0; g < NB; g++)
		begin : g_bank
			assign bif[g].addr_hi    = CYC_ADDR_I[31:16];
			assign bif[g].is_write   = !CYC_READ_I;
			assign bif[g].usable     = !boot_ff;
			assign bif[g].base       = base_ff[g][csdec_pkg::ADDR_FIELD_LSB +: 16];
			assign bif[g].mask       = mask_ff[g][csdec_pkg::ADDR_FIELD_LSB +: 16];
			assign bif[g].valid      = mask_ff[g][csdec_pkg::MASK_VALID_BIT];
			assign bif[g].wr_protect = mask_ff[g][csdec_pkg::MASK_WP_BIT];
			// boot bank matches every access while the catch-all stands
			assign bank_hit[g] = bif[g].hit || (g == 0 && boot_ff);
			bank_match u_match (
				.m (bif[g])
			);
		end
	endgenerate

	// match classification and attributes of the cycle being started
	logic [3:0]  hit_count;
	logic        single_hit;
	logic [31:0] hit_ctrl;
	logic [1:0]  cyc_pw;
	logic [3:0]  lanes;
	always_comb
	begin
		hit_count = 4'h0;
		hit_ctrl  = 32'h00000000;
		for (int b = 0; b < NB; b++)
		begin
			hit_count = hit_count + {3'h0, bank_hit[b]};
			if (bank_hit[b])
				hit_ctrl = hit_ctrl | ctrl_ff[b];
		end
		single_hit = (hit_count == 4'h1);
		// none or several matches fall back to a 32-bit port
		cyc_pw = single_hit ? hit_ctrl[csdec_pkg::CTRL_PW_LSB +: 2] : csdec_pkg::PW_32;
		// lane decode, active high here
		if (cyc_pw == csdec_pkg::PW_8)
			lanes = csdec_pkg::LANES_TOP;
		else if (cyc_pw[1])
			lanes = (CYC_SIZE_I == csdec_pkg::SZ_BYTE) ?
				(CYC_ADDR_I[0] ? csdec_pkg::LANES_SECOND : csdec_pkg::LANES_TOP) : csdec_pkg::LANES_UPPER;
		else
		begin
			case (CYC_SIZE_I)
				csdec_pkg::SZ_BYTE: lanes = csdec_pkg::LANES_TOP >> CYC_ADDR_I[1:0];
				csdec_pkg::SZ_WORD: lanes = CYC_ADDR_I[1] ? csdec_pkg::LANES_LOWER : csdec_pkg::LANES_UPPER;
				default:            lanes = csdec_pkg::LANES_ALL;
			endcase
		end
	end

	// bus cycle sequencing
	typedef enum logic [0:0] {ST_IDLE, ST_ACTIVE} cyc_state_t;
	cyc_state_t  state_ff, nxt_state;
	logic [7:0]  cs_n_ff, nxt_cs_n;
	logic [3:0]  strobe_n_ff, nxt_strobe_n;
	logic [3:0]  lane_oe_ff, nxt_lane_oe;
	logic        read_ff, nxt_read;
	logic        ext_term_ff, nxt_ext_term;
	logic        burst_ff, nxt_burst;
	logic [1:0]  pw_ff, nxt_pw;
	logic [3:0]  waits_ff, nxt_waits;
	logic [3:0]  wcnt_ff, nxt_wcnt;
	logic        done_ff, nxt_done;
	logic        ack_ff, nxt_ack;
	always_comb
	begin
		nxt_state    = state_ff;
		nxt_cs_n     = cs_n_ff;
		nxt_strobe_n = strobe_n_ff;
		nxt_lane_oe  = lane_oe_ff;
		nxt_read     = read_ff;
		nxt_ext_term = ext_term_ff;
		nxt_burst    = burst_ff;
		nxt_pw       = pw_ff;
		nxt_waits    = waits_ff;
		nxt_wcnt     = wcnt_ff;
		nxt_done     = 1'b0;
		nxt_ack      = 1'b0;
		case (state_ff)
			ST_IDLE:
			begin
				// dram blocks own the cycle when they match; overlaps are left undefined
				if (CYC_START_I && DRAM_HIT_I == 2'h0)
				begin
					nxt_state    = ST_ACTIVE;
					nxt_cs_n     = ~bank_hit;
					nxt_read     = CYC_READ_I;
					nxt_pw       = cyc_pw;
					nxt_ext_term = !(single_hit && hit_ctrl[csdec_pkg::CTRL_AA_BIT]);
					nxt_burst    = single_hit &&
						(CYC_READ_I ? hit_ctrl[csdec_pkg::CTRL_BSTR_BIT] : hit_ctrl[csdec_pkg::CTRL_BSTW_BIT]);
					nxt_waits    = single_hit ? hit_ctrl[csdec_pkg::CTRL_WS_LSB +: 4] : 4'h0;
					nxt_wcnt     = 4'h0;
					// byte enables on both directions, write enables on writes only
					nxt_strobe_n = (!CYC_READ_I || (single_hit && hit_ctrl[csdec_pkg::CTRL_BEM_BIT])) ?
						~lanes : 4'hF;
					nxt_lane_oe  = CYC_READ_I ? 4'h0 : 4'hF;
				end
			end
			ST_ACTIVE:
			begin
				if (ext_term_ff ? ext_ta_seen : (wcnt_ff == waits_ff))
				begin
					// end of cycle: everything back to negated
					nxt_state    = ST_IDLE;
					nxt_cs_n     = 8'hFF;
					nxt_strobe_n = 4'hF;
					nxt_lane_oe  = 4'h0;
					nxt_done     = 1'b1;
					nxt_ack      = !ext_term_ff;
				end
				else if (!ext_term_ff)
					nxt_wcnt = wcnt_ff + 4'h1;
			end
			default:
				nxt_state = ST_IDLE;
		endcase
	end

	// register the cycle group
	always_ff @(posedge CLK_I or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_ff    <= ST_IDLE;
			cs_n_ff     <= 8'hFF;
			strobe_n_ff <= 4'hF;
			lane_oe_ff  <= 4'h0;
			read_ff     <= 1'b0;
			ext_term_ff <= 1'b1;
			burst_ff    <= 1'b0;
			pw_ff       <= csdec_pkg::PW_32;
			waits_ff    <= 4'h0;
			wcnt_ff     <= 4'h0;
			done_ff     <= 1'b0;
			ack_ff      <= 1'b0;
		end
		else
		begin
			state_ff    <= nxt_state;
			cs_n_ff     <= nxt_cs_n;
			strobe_n_ff <= nxt_strobe_n;
			lane_oe_ff  <= nxt_lane_oe;
			read_ff     <= nxt_read;
			ext_term_ff <= nxt_ext_term;
			burst_ff    <= nxt_burst;
			pw_ff       <= nxt_pw;
			waits_ff    <= nxt_waits;
			wcnt_ff     <= nxt_wcnt;
			done_ff     <= nxt_done;
			ack_ff      <= nxt_ack;
		end
	end

	// read strobe, moved on the falling edge only
	logic oe_n_ff, nxt_oe_n;
	always_comb
	begin
		nxt_oe_n = !(state_ff == ST_ACTIVE && read_ff && cs_n_ff != 8'hFF);
	end
	always_ff @(negedge CLK_I or negedge rst_n)
	begin
		if (!rst_n)
			oe_n_ff <= 1'b1;
		else
			oe_n_ff <= nxt_oe_n;
	end

	// outputs
	assign CS_N_O           = cs_n_ff;
	assign OE_N_O           = oe_n_ff;
	assign LANE_STROBE_N_O  = strobe_n_ff;
	assign DATA_LANE_OE_O   = lane_oe_ff;
	assign CYC_ACTIVE_O     = (state_ff == ST_ACTIVE);
	assign CYC_BURST_OK_O   = burst_ff;
	assign CYC_EXT_TERM_O   = ext_term_ff;
	assign CYC_PORT_WIDTH_O = pw_ff;
	assign CYC_DONE_O       = done_ff;
	assign AUTO_ACK_O       = ack_ff;
endmodule
`default_nettype wire

// ### tb/ext_mem_model.sv
// far-side memory model that ends externally terminated cycles
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
	// clock and cycle status
	input  wire logic CLK_I,
	input  wire logic cyc_active_i,
	input  wire logic ext_term_i,
	input  wire logic cyc_done_i,
	// acknowledge pin, pulled high when released
	output logic      ext_ta_n_o
);
	logic [1:0] wait_ff;  // cycles into the cycle
	logic [1:0] nxt_wait;
	logic       nxt_ta_n;
	// acknowledge three cycles in, release at done
	always_comb
	begin
		nxt_wait = (cyc_active_i && ext_term_i) ? wait_ff + 2'(wait_ff != 2'h3) : 2'h0;
		nxt_ta_n = (nxt_wait != 2'h3) || cyc_done_i;
	end
	always_ff @(posedge CLK_I)
	begin
		wait_ff    <= nxt_wait;
		ext_ta_n_o <= nxt_ta_n;
	end
endmodule
`default_nettype wire

// ### tb/csdec_sva.sv
// assertion checker for the chip-select decode unit
`timescale 1ns/1ps
`default_nettype none
module csdec_sva (
	// watched ports
	input wire logic       CLK_I,
	input wire logic       RSTN_I,
	input wire logic       CYC_START_I,
	input wire logic       CYC_READ_I,
	input wire logic [1:0] DRAM_HIT_I,
	input wire logic [7:0] CS_N_O,
	input wire logic       OE_N_O,
	input wire logic [3:0] LANE_STROBE_N_O,
	input wire logic [3:0] DATA_LANE_OE_O,
	input wire logic       CYC_ACTIVE_O,
	input wire logic       CYC_BURST_OK_O,
	input wire logic       CYC_EXT_TERM_O,
	input wire logic [1:0] CYC_PORT_WIDTH_O,
	input wire logic       CYC_DONE_O,
	input wire logic       AUTO_ACK_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RSTN_I);
	logic oe_at_rise; // read strobe as seen at the rising edge
	always_ff @(posedge CLK_I) oe_at_rise <= OE_N_O;
	// an accepted cycle start
	sequence s_take;
		CYC_START_I && !CYC_ACTIVE_O && DRAM_HIT_I == 2'h0;
	endsequence
	chk_idle_negated: assert property (!CYC_ACTIVE_O |-> CS_N_O == 8'hFF && LANE_STROBE_N_O == 4'hF)
		else $error("outputs asserted while idle");
	chk_oe_with_cs: assert property (!OE_N_O |-> CS_N_O != 8'hFF)
		else $error("read strobe without select");
	chk_oe_fall_only: assert property (@(negedge CLK_I) disable iff (!RSTN_I) OE_N_O == oe_at_rise)
		else $error("read strobe moved on rising edge");
	chk_start_runs: assert property (s_take |=> CYC_ACTIVE_O)
		else $error("start not taken");
	chk_dram_idle: assert property (CYC_START_I && !CYC_ACTIVE_O && DRAM_HIT_I != 2'h0 |=> !CYC_ACTIVE_O)
		else $error("cycle run on dram hit");
	chk_write_lanes: assert property (s_take ##0 !CYC_READ_I |=> DATA_LANE_OE_O == 4'hF ##1
		(!CYC_ACTIVE_O || DATA_LANE_OE_O == 4'hF))
		else $error("write lanes not driven");
	chk_multi_ext: assert property ($countones(~CS_N_O) > 1 |-> CYC_EXT_TERM_O && !CYC_BURST_OK_O
		&& CYC_PORT_WIDTH_O == csdec_pkg::PW_32)
		else $error("multi match attributes wrong");
	chk_ack_done: assert property (AUTO_ACK_O |-> CYC_DONE_O)
		else $error("auto ack without done");
	chk_done_pulse: assert property (CYC_DONE_O |=> !CYC_DONE_O)
		else $error("done longer than one cycle");
endmodule
bind chip_select_decode_unit csdec_sva u_csdec_sva (.CLK_I, .RSTN_I, .CYC_START_I, .CYC_READ_I, .DRAM_HIT_I,
	.CS_N_O, .OE_N_O, .LANE_STROBE_N_O, .DATA_LANE_OE_O, .CYC_ACTIVE_O, .CYC_BURST_OK_O, .CYC_EXT_TERM_O,
	.CYC_PORT_WIDTH_O, .CYC_DONE_O, .AUTO_ACK_O);
`default_nettype wire

// ### tb/chip_select_decode_unit_tb.sv
// self-checking bench for the chip-select decode unit
`timescale 1ns/1ps
`default_nettype none
module chip_select_decode_unit_tb;
	logic        clk, rstn = 1'b0, awv = 1'b0, wv = 1'b0, arv = 1'b0, start = 1'b0, rd = 1'b0;
	logic [11:0] awa = 12'h0, ara = 12'h0;
	logic [31:0] wd = 32'h0, addr = 32'h0, rdat;
	logic [1:0]  sz = 2'h0, dram = 2'h0, br, rr, pw;
	logic [2:0]  strap = 3'h0;
	logic        awr, wr_r, bv, arr, rv, oe_n, act, bok, ext, done, aa, ta_n;
	logic [7:0]  cs_n;
	logic [3:0]  ls_n, loe;
	int          mismatches = 0, tests_run = 0, i;
	logic [2:0]  straps [3] = '{3'h6, 3'h1, 3'h0};  // strap settings tried
	logic [3:0]  blanes [3] = '{4'hB, 4'h7, 4'hE};  // lanes for a byte at offset 3
	logic [9:0]  tbl [8] = '{10'h017, 10'h11B, 10'h21D, 10'h31E, 10'h023, 10'h22C, 10'h000, 10'h030};
	chip_select_decode_unit u_chip_select_decode_unit (.CLK_I(clk), .RSTN_I(rstn), .S_AXI_AWADDR_I(awa),
		.S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hF),
		.S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr_r), .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv),
		.S_AXI_BREADY_I(1'b1), .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
		.S_AXI_RDATA_O(rdat), .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(1'b1),
		.CYC_START_I(start), .CYC_ADDR_I(addr), .CYC_SIZE_I(sz), .CYC_READ_I(rd), .DRAM_HIT_I(dram),
		.DATA_STRAP_I(strap), .EXT_TA_N_I(ta_n), .CS_N_O(cs_n), .OE_N_O(oe_n), .LANE_STROBE_N_O(ls_n),
		.DATA_LANE_OE_O(loe), .CYC_ACTIVE_O(act), .CYC_BURST_OK_O(bok), .CYC_EXT_TERM_O(ext),
		.CYC_PORT_WIDTH_O(pw), .CYC_DONE_O(done), .AUTO_ACK_O(aa));
	ext_mem_model u_ext_mem_model (.CLK_I(clk), .cyc_active_i(act), .ext_term_i(ext), .cyc_done_i(done),
		.ext_ta_n_o(ta_n));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic complete_run;
		$display("counts: %0d compares, %0d mismatches", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e)
		begin
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
			mismatches++;
		end
	endtask
	// reset with a strap value held across the release
	task automatic boot(input logic [2:0] s);
		@(posedge clk);
		rstn <= 1'b0;
		strap <= s;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		repeat (6) @(posedge clk);
	endtask
	// axi write, handshakes judged from settled values before each edge
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		int n;
		logic ah, wh, bh;
		@(posedge clk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		for (n = 0; n < 40; n++)
		begin
			@(negedge clk);
			ah = awv & awr;
			wh = wv & wr_r;
			bh = bv;
			if (bh) chk(32'(br), 32'(csdec_pkg::RESP_OKAY));
			@(posedge clk);
			if (ah) awv <= 1'b0;
			if (wh) wv <= 1'b0;
			if (bh) break;
		end
		if (n == 40) begin mismatches++; complete_run; end
	endtask
	// axi read compared against data and response
	task automatic rdc(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		logic rh, ah;
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		for (n = 0; n < 40; n++)
		begin
			@(negedge clk);
			rh = rv;
			ah = arr;
			if (rh) begin chk(rdat, ed); chk(32'(rr), 32'(er)); end
			@(posedge clk);
			if (ah) arv <= 1'b0;
			if (rh) break;
		end
		if (n == 40) begin mismatches++; complete_run; end
	endtask
	// one bus cycle: selects, lanes, width, termination, read strobe, ack
	task automatic cyc(input logic [31:0] a, input logic [1:0] s, input logic r, input logic [7:0] ecs,
		input logic [3:0] els, input logic [1:0] epw, input logic eext, input logic eaa);
		int n;
		@(posedge clk);
		start <= 1'b1;
		addr <= a;
		sz <= s;
		rd <= r;
		@(posedge clk);
		start <= 1'b0;
		#1 chk(32'({cs_n, ls_n, pw, ext, bok}), 32'({ecs, els, epw, eext, r && ecs == 8'hFD}));
		@(negedge clk);
		#1 chk(32'(oe_n), 32'(!r || ecs == 8'hFF));
		for (n = 0; n < 40; n++)
		begin
			@(posedge clk);
			#1 if (done === 1'b1) break;
		end
		if (n == 40) begin mismatches++; complete_run; end
		chk(32'(aa), 32'(eaa));
		repeat (4) @(posedge clk);
	endtask
	initial
	begin
		repeat (20000) @(posedge clk);
		mismatches++;
		complete_run;
	end
	// main sequence
	initial
	begin
		for (i = 0; i < 3; i++)
		begin
			boot(straps[i]);
			cyc(32'h5A5A0003, csdec_pkg::SZ_BYTE, 1'b0, 8'hFE, blanes[i], straps[i][1:0], !straps[i][2], straps[i][2]);
			$display("test boot strap %0d done", i);
		end
		rdc(12'h084, 32'h0, csdec_pkg::RESP_OKAY);
		rdc(12'h000, 32'h0, csdec_pkg::RESP_SLVERR);
		wr(12'h080, 32'h10000000);
		wr(12'h084, 32'h00000001);
		wr(12'h08C, 32'h20000000);
		wr(12'h094, 32'h00000930);
		wr(12'h090, 32'h00000001);
		rdc(12'h094, 32'h00000930, csdec_pkg::RESP_OKAY);
		cyc(32'h5A5A0000, csdec_pkg::SZ_LONG, 1'b1, 8'hFF, 4'hF, 2'h0, 1'b1, 1'b0);
		for (i = 0; i < 8; i++)
			cyc({30'h08000000, tbl[i][9:8]}, tbl[i][5:4], 1'b1, 8'hFD, tbl[i][3:0], 2'h0, 1'b0, 1'b1);
		$display("test lane table done");
		wr(12'h098, 32'h20000000);
		wr(12'h09C, 32'h00000001);
		cyc(32'h20000000, csdec_pkg::SZ_LONG, 1'b0, 8'hF9, 4'h0, 2'h0, 1'b1, 1'b0);
		@(posedge clk);
		start <= 1'b1;
		dram <= 2'h1;
		@(posedge clk);
		start <= 1'b0;
		dram <= 2'h0;
		#1 chk(32'({act, cs_n}), 32'h0FF);
		$display("test match cases done");
		complete_run;
	end
endmodule
`default_nettype wire
